// [design/pin_noise_filter.v]
`timescale 1ns/1ps
`include "timer_ctl_regs.vh"

module pin_noise_filter (
  input  wire clk_sys_i,
  input  wire rst_b_i,
  input  wire sample_i,
  input  wire en_i,
  input  wire pin_i,
  output reg  level_o
);

  reg [`FLT_SAMPLES-1:0] hist_q;

  // Level changes only after all samples agree; bypass when off
  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hist_q  <= {`FLT_SAMPLES{1'b0}};
      level_o <= 1'b0;
    end
    else if (!en_i)
    begin
      hist_q  <= {`FLT_SAMPLES{pin_i}};
      level_o <= pin_i;
    end
    else if (sample_i)
    begin
      hist_q <= {hist_q[`FLT_SAMPLES-2:0], pin_i};
      if (&{hist_q[`FLT_SAMPLES-2:0], pin_i})
        level_o <= 1'b1;
      else if (~|{hist_q[`FLT_SAMPLES-2:0], pin_i})
        level_o <= 1'b0;
    end
  end

endmodule // pin_noise_filter

// [design/timer_ctl_regs.vh]
`ifndef TIMER_CTL_REGS_VH
`define TIMER_CTL_REGS_VH

// Register byte offsets (AXI4-Lite, one word each)
`define OFS_FLT_CTRL_0    8'h00
`define OFS_FLT_CTRL_1    8'h04
`define OFS_CH_CTRL_0     8'h08
`define OFS_CH_CTRL_1     8'h0C
`define OFS_CUT_EN_STAT   8'h10
`define OFS_EVT_LINK_SEL  8'h14
`define OFS_CH_START      8'h18
`define OFS_MODE          8'h1C
`define OFS_GEN_A_0       8'h20
`define OFS_GEN_A_1       8'h24
`define OFS_COUNT_0       8'h28
`define OFS_COUNT_1       8'h2C
`define OFS_IRQ_STAT      8'h30
`define OFS_IRQ_MASK      8'h34
`define OFS_LAST_WORD     6'h0D

// Filter control fields
`define FLT_EN_LSB        0
`define FLT_CH0_B_CUT     4
`define FLT_CH1_B_CUT     5
`define FLT_CLK_LSB       6
// Count source field
`define CNT_SRC_LSB       0
// Cutoff enable/status fields
`define CUT_FLAG_BIT      0
`define CUT_IN_EN_BIT     7
// Event link select fields
`define EVT_CAP_SEL_BIT0  0
`define EVT_CUT_EN_BIT0   1
`define EVT_CAP_SEL_BIT1  4
`define EVT_CUT_EN_BIT1   5
`define EVT_LINK_MASK     8'h33
// Start register fields
`define RUN_BIT0          0
`define MATCH_SEL_BIT0    2
// Mode register fields
`define MODE_3PH_BIT      0
`define MODE_HS_OSC_BIT   1

// Count source codes
`define SRC_DIV1          3'h0
`define SRC_DIV2          3'h1
`define SRC_DIV4          3'h2
`define SRC_DIV8          3'h3
`define SRC_DIV32         3'h4
`define SRC_EXT           3'h5
// Filter clock codes
`define FCK_DIV32         2'h0
`define FCK_DIV8          2'h1
`define FCK_DIV1          2'h2
`define FCK_SRC           2'h3

// Reset values
`define RST_BYTE          8'h00
`define RST_WORD          16'h0000

// Filter agreement length in samples
`define FLT_SAMPLES       3

// AXI responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// [design/timer_ctl_top.v]
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "timer_ctl_regs.vh"
// Contract
// - Per-pin noise filter with own enable bit
// - Filter clock: /32, /8, undivided, count source
// - High-speed flag moves /32, /8 and undivided filter clocks to oscillator; count source pick unchanged
// - Per-channel bit puts B pin into cutoff
// - Count source decode; codes 110/111 forbidden
// - External cutoff input only when enabled
// - Any forced cutoff sets the cutoff flag
// - Event may replace pin as capture trigger
// - Event may force cutoff of channel outputs
// - Match select: keep counting or stop

module timer_ctl_top (
  input  wire        clk_sys_i,
  input  wire        rst_b_i,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  input  wire        hs_osc_clk_i,
  input  wire        external_count_clock_pin_i,
  input  wire        cutoff_in_b_i,
  input  wire [7:0]  capture_pwm_pin_i,
  input  wire [7:0]  pwm_level_i,
  input  wire [7:0]  pwm_oe_i,
  input  wire [1:0]  event_capture_i,
  input  wire [1:0]  event_cutoff_i,
  output reg  [7:0]  capture_pwm_pin_o,
  output reg  [7:0]  capture_pwm_pin_oe_o,
  output reg  [7:0]  filtered_pin_o,
  output reg  [1:0]  capture_trigger_o,
  output reg         irq_o
);

  // Software-visible state
  reg  [15:0] flt_ctrl_q;
  reg  [5:0]  count_src_q;
  reg         cutoff_input_enable_q;
  reg  [7:0]  evt_link_q;
  reg  [3:0]  start_q;
  reg  [1:0]  mode_q;
  reg  [31:0] gen_a_q;
  reg  [3:0]  irq_stat_q;
  reg  [3:0]  irq_mask_q;
  reg  [1:0]  cut_q;
  // Bus slave state
  reg  [7:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg  [31:0] rd_mux;
  // Synchronisers and edge history
  reg  [7:0]  pin_meta_q;
  reg  [7:0]  pin_sync_q;
  reg  [2:0]  misc_meta_q;
  reg  [2:0]  misc_sync_q;
  reg         hs_prev_q;
  reg         ext_prev_q;
  reg  [1:0]  pin_a_prev_q;
  reg  [4:0]  sys_div_q;
  reg  [4:0]  hs_div_q;

  wire        hs_tick;
  wire        ext_tick;
  wire        ext_cut;
  wire        wr_go;
  wire        rd_go;
  wire [1:0]  src_tick;
  wire [1:0]  flt_tick;
  wire [1:0]  match;
  wire [1:0]  cut_evt;
  wire [1:0]  cap_evt;
  wire [7:0]  filt;
  wire [31:0] cnt_word;

  // True when an address hits a mapped word
  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr[7:2] <= `OFS_LAST_WORD);
    end
  endfunction

  // One-cycle divider tick from a free counter: 0=/1 .. 4=/32
  function div_tick;
    input [4:0] cnt;
    input [2:0] ratio;
    begin
      case (ratio)
        3'h0:    div_tick = 1'b1;
        3'h1:    div_tick = cnt[0];
        3'h2:    div_tick = &cnt[1:0];
        3'h3:    div_tick = &cnt[2:0];
        3'h4:    div_tick = &cnt[4:0];
        default: div_tick = 1'b0;
      endcase
    end
  endfunction

  // Byte-lane merge for narrow writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          merge[8*k +: 8] = data[8*k +: 8];
    end
  endfunction

  // Lane-merged general A words; only the low half is kept
  wire [31:0] ga0_m = merge({16'h0000, gen_a_q[15:0]}, w_data_q, w_strb_q);
  wire [31:0] ga1_m = merge({16'h0000, gen_a_q[31:16]}, w_data_q, w_strb_q);

  // Two-flop synchronisers for every pin
  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_meta_q  <= 8'h00;
      pin_sync_q  <= 8'h00;
      misc_meta_q <= 3'h4;
      misc_sync_q <= 3'h4;
    end
    else
    begin
      pin_meta_q  <= capture_pwm_pin_i;
      pin_sync_q  <= pin_meta_q;
      misc_meta_q <= {cutoff_in_b_i, external_count_clock_pin_i,
                      hs_osc_clk_i};
      misc_sync_q <= misc_meta_q;
    end
  end

  assign hs_tick  = misc_sync_q[0] & ~hs_prev_q;
  assign ext_tick = misc_sync_q[1] & ~ext_prev_q;
  assign ext_cut  = ~misc_sync_q[2] & cutoff_input_enable_q;

  // Prescalers; oscillator edges sampled, so it must run below half fclk
  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hs_prev_q  <= 1'b0;
      ext_prev_q <= 1'b0;
      sys_div_q  <= 5'h00;
      hs_div_q   <= 5'h00;
    end
    else
    begin
      hs_prev_q  <= misc_sync_q[0];
      ext_prev_q <= misc_sync_q[1];
      sys_div_q  <= sys_div_q + 5'h01;
      if (hs_tick)
        hs_div_q <= hs_div_q + 5'h01;
    end
  end

  // Per-channel clocking, counter and cutoff
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1)
    begin : ch
      reg  [15:0] cnt_q;
      wire [2:0]  src   = count_src_q[3*c +: 3];
      wire [1:0]  fck   = flt_ctrl_q[8*c+`FLT_CLK_LSB +: 2];
      wire        hs_on = mode_q[`MODE_HS_OSC_BIT];
      wire [2:0]  fdiv  = (fck == `FCK_DIV32) ? 3'h4 :
                          (fck == `FCK_DIV8)  ? 3'h3 : 3'h0;

      assign src_tick[c] = (src == `SRC_EXT) ? ext_tick :
                           div_tick(sys_div_q, src);
      assign flt_tick[c] = (fck == `FCK_SRC) ? src_tick[c] :
                           hs_on ? (hs_tick & div_tick(hs_div_q, fdiv)) :
                           div_tick(sys_div_q, fdiv);
      assign match[c]   = start_q[`RUN_BIT0+c] & src_tick[c] &
                          (cnt_q == gen_a_q[16*c +: 16]);
      assign cut_evt[c] = ext_cut |
                          (evt_link_q[`EVT_CUT_EN_BIT0+4*c] &
                           event_cutoff_i[c]);
      assign cap_evt[c] = evt_link_q[`EVT_CAP_SEL_BIT0+4*c] ?
                          event_capture_i[c] :
                          (filt[4*c] & ~pin_a_prev_q[c]);
      assign cnt_word[16*c +: 16] = cnt_q;

      // Count only while running; match either wraps or stops
      always @(posedge clk_sys_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
          cnt_q <= `RST_WORD;
        else if (match[c])
        begin
          if (start_q[`MATCH_SEL_BIT0+c])
            cnt_q <= `RST_WORD;
        end
        else if (start_q[`RUN_BIT0+c] & src_tick[c])
          cnt_q <= cnt_q + 16'h0001;
      end
    end
  endgenerate

  // Noise filters, four pins per channel
  genvar p;
  generate
    for (p = 0; p < 8; p = p + 1)
    begin : pin
      pin_noise_filter u_flt (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .sample_i  (flt_tick[p/4]),
        .en_i      (flt_ctrl_q[8*(p/4)+`FLT_EN_LSB+(p%4)]),
        .pin_i     (pin_sync_q[p]),
        .level_o   (filt[p])
      );
    end
  endgenerate

  // Pin drive: cut pins float; B pin only if its bit allows
  integer q;
  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      capture_pwm_pin_o    <= 8'h00;
      capture_pwm_pin_oe_o <= 8'h00;
    end
    else
    begin
      capture_pwm_pin_o <= pwm_level_i;
      for (q = 0; q < 8; q = q + 1)
        capture_pwm_pin_oe_o[q] <= pwm_oe_i[q] & ~(cut_q[q/4] &
          ((q%4 != 1) | flt_ctrl_q[8*(q/4)+`FLT_CH0_B_CUT+q/4]));
    end
  end

  // Capture triggers, filtered levels, interrupt line
  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_a_prev_q      <= 2'h0;
      capture_trigger_o <= 2'h0;
      filtered_pin_o    <= 8'h00;
      irq_o             <= 1'b0;
    end
    else
    begin
      pin_a_prev_q      <= {filt[4], filt[0]};
      capture_trigger_o <= cap_evt;
      filtered_pin_o    <= filt;
      irq_o             <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign wr_go = awready == 1'b0 && wready == 1'b0 && !bvalid;
  assign rd_go = arvalid && arready;

  // Write channel: take address and data in any order, then answer
  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OKAY;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
    end
    else
    begin
      if (awready && awvalid)
      begin
        awready   <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (wready && wvalid)
      begin
        wready   <= 1'b0;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_go)
      begin
        bvalid <= 1'b1;
        bresp  <= mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Read data selection
  always @*
  begin
    rd_mux = 32'h00000000;
    case ({araddr[7:2], 2'b00})
      `OFS_FLT_CTRL_0:   rd_mux[7:0]  = flt_ctrl_q[7:0];
      `OFS_FLT_CTRL_1:   rd_mux[7:0]  = flt_ctrl_q[15:8];
      `OFS_CH_CTRL_0:    rd_mux[2:0]  = count_src_q[2:0];
      `OFS_CH_CTRL_1:    rd_mux[2:0]  = count_src_q[5:3];
      `OFS_CUT_EN_STAT:  rd_mux[7:0]  = {cutoff_input_enable_q, 6'h00,
                                         |cut_q};
      `OFS_EVT_LINK_SEL: rd_mux[7:0]  = evt_link_q;
      `OFS_CH_START:     rd_mux[3:0]  = start_q;
      `OFS_MODE:         rd_mux[1:0]  = mode_q;
      `OFS_GEN_A_0:      rd_mux[15:0] = gen_a_q[15:0];
      `OFS_GEN_A_1:      rd_mux[15:0] = gen_a_q[31:16];
      `OFS_COUNT_0:      rd_mux[15:0] = cnt_word[15:0];
      `OFS_COUNT_1:      rd_mux[15:0] = cnt_word[31:16];
      `OFS_IRQ_STAT:     rd_mux[3:0]  = irq_stat_q;
      `OFS_IRQ_MASK:     rd_mux[3:0]  = irq_mask_q;
      default:           rd_mux       = 32'h00000000;
    endcase
  end

  // Read channel: one-cycle answer held until taken
  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `RESP_OKAY;
    end
    else if (rd_go)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_mux;
      rresp   <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Register file; hardware set beats software clear
  always @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      flt_ctrl_q            <= {`RST_BYTE, `RST_BYTE};
      count_src_q           <= 6'h00;
      cutoff_input_enable_q <= 1'b0;
      evt_link_q            <= `RST_BYTE;
      start_q               <= 4'h0;
      mode_q                <= 2'h0;
      gen_a_q               <= {`RST_WORD, `RST_WORD};
      irq_mask_q            <= 4'h0;
      irq_stat_q            <= 4'h0;
      cut_q                 <= 2'h0;
    end
    else
    begin
      if (wr_go && w_strb_q[0])
        case ({aw_addr_q[7:2], 2'b00})
          `OFS_FLT_CTRL_0:   flt_ctrl_q[7:0]  <= w_data_q[7:0];
          `OFS_FLT_CTRL_1:   flt_ctrl_q[15:8] <= w_data_q[7:0];
          `OFS_CH_CTRL_0:    count_src_q[2:0] <= w_data_q[2:0];
          `OFS_CH_CTRL_1:    count_src_q[5:3] <= w_data_q[2:0];
          `OFS_CUT_EN_STAT:  cutoff_input_enable_q <=
                               w_data_q[`CUT_IN_EN_BIT];
          `OFS_EVT_LINK_SEL: evt_link_q <= w_data_q[7:0] & `EVT_LINK_MASK;
          `OFS_MODE:         mode_q     <= w_data_q[1:0];
          `OFS_IRQ_MASK:     irq_mask_q <= w_data_q[3:0];
          default:           ;
        endcase
      if (wr_go && {aw_addr_q[7:2], 2'b00} == `OFS_GEN_A_0)
        gen_a_q[15:0]  <= ga0_m[15:0];
      if (wr_go && {aw_addr_q[7:2], 2'b00} == `OFS_GEN_A_1)
        gen_a_q[31:16] <= ga1_m[15:0];
      // Stop on match when the keep-counting bit is clear
      if (wr_go && w_strb_q[0] &&
          {aw_addr_q[7:2], 2'b00} == `OFS_CH_START)
        start_q <= w_data_q[3:0];
      else
        start_q <= start_q & ~({2'b00, match} &
                   ~{2'b00, start_q[3:2]});
      // Writing 0 to the flag clears it; a new cut still wins
      if (wr_go && w_strb_q[0] && ~w_data_q[`CUT_FLAG_BIT] &&
          {aw_addr_q[7:2], 2'b00} == `OFS_CUT_EN_STAT)
        cut_q <= cut_evt;
      else
        cut_q <= cut_q | cut_evt;
      // Status clears on read; new events win over the clear
      irq_stat_q <= (irq_stat_q &
                     ~((rd_go && {araddr[7:2], 2'b00} == `OFS_IRQ_STAT)
                       ? 4'hF : 4'h0)) | {match, cut_evt};
    end
  end

endmodule // timer_ctl_top

// [testbench/pin_side_model.sv]
`timescale 1ns/1ps
module pin_side_model (
  input  wire logic       clk_sys_i,
  input  wire logic       ext_run_i,
  input  wire logic       hs_run_i,
  output logic            ext_clk_o,
  output logic            hs_clk_o,
  output logic [7:0]      pwm_level_o,
  output logic [7:0]      pwm_oe_o
);
  // Board clocks, unrelated to the system clock, low while idle
  initial
  begin
    ext_clk_o = 1'b0;
    hs_clk_o = 1'b0;
    pwm_level_o = 8'h00;
  end
  always #23 ext_clk_o = ext_run_i & ~ext_clk_o;
  always #13 hs_clk_o = hs_run_i & ~hs_clk_o; // Kept under 50 MHz
  // Engine levels change every cycle so stale drive shows up
  always @(posedge clk_sys_i) pwm_level_o <= 8'($urandom);
  assign pwm_oe_o = 8'hFF;
endmodule // pin_side_model

// [testbench/timer_ctl_properties.sv]
`timescale 1ns/1ps
module timer_ctl_properties (
  input wire logic        clk_sys_i,
  input wire logic        rst_b_i,
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [7:0]  pwm_level_i,
  input wire logic [7:0]  pwm_oe_i,
  input wire logic [7:0]  capture_pwm_pin_o,
  input wire logic [7:0]  capture_pwm_pin_oe_o,
  input wire logic [1:0]  capture_trigger_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // Bus answers come at the promised edge and stand until taken
  a_b_latency: assert property (
    awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write response not two cycles after request");
  a_r_latency: assert property (arvalid && arready |=> rvalid)
    else $error("read data not one cycle after request");
  a_b_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
  a_r_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before taken");
  a_one_write: assert property (bvalid |-> !awready && !wready)
    else $error("second write accepted while one is open");
  // Holes in the map answer with an error code
  a_rd_unmapped: assert property (arvalid && arready && araddr[7:2] > 6'h0D
    |=> rresp == 2'h2 && rdata == 32'h0)
    else $error("unmapped read not refused");
  a_wr_unmapped: assert property (awvalid && awready && wvalid && wready
    && awaddr[7:2] > 6'h0D |=> ##1 bresp == 2'h2)
    else $error("unmapped write not refused");
  // Pin drive follows the engine one cycle later, enables only cut away
  a_level_delay: assert property (
    $past(rst_b_i) |-> capture_pwm_pin_o == $past(pwm_level_i))
    else $error("pin level not engine level delayed");
  a_oe_only_cut: assert property (
    $past(rst_b_i) |-> (capture_pwm_pin_oe_o & ~$past(pwm_oe_i)) == 8'h00)
    else $error("pin enabled without engine request");
  a_trig_pulse: assert property (
    capture_trigger_o[0] |=> !capture_trigger_o[0])
    else $error("capture trigger longer than one cycle");
endmodule // timer_ctl_properties

bind timer_ctl_top timer_ctl_properties timer_ctl_properties_i (
  .clk_sys_i, .rst_b_i, .awaddr, .awvalid, .awready, .wvalid, .wready,
  .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
  .rvalid, .rready, .pwm_level_i, .pwm_oe_i, .capture_pwm_pin_o,
  .capture_pwm_pin_oe_o, .capture_trigger_o);

// [testbench/timer_filter_cutoff_control_bench.sv]
`timescale 1ns/1ps
module timer_filter_cutoff_control_bench;
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, pin = 8'h00;
  logic [31:0] wdata = 32'h0, v, d;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        ext_run = 0, hs_run = 0, cut_b = 1, h;
  logic [1:0]  ev_cap = 2'h0, ev_cut = 2'h0, bresp, rresp, resp, trig;
  wire         awready, wready, bvalid, arready, rvalid, irq, ext_clk, hs_clk;
  wire  [31:0] rdata;
  wire  [7:0]  pin_o, oe_o, flt, pwm_lv, pwm_oe;
  logic [31:0] m [0:13];
  logic [31:0] msk [0:13];
  int          n_errors = 0, check_count = 0, trig_n = 0, t0, s, k;

  always #5 clk_sys_i = ~clk_sys_i;
  // Captures counted as the block reports them
  always @(posedge clk_sys_i) if (trig[0] === 1'b1) trig_n <= trig_n + 1;

  timer_ctl_top timer_ctl_top_i (.clk_sys_i, .rst_b_i, .awaddr, .awvalid,
    .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .hs_osc_clk_i(hs_clk), .external_count_clock_pin_i(ext_clk),
    .cutoff_in_b_i(cut_b), .capture_pwm_pin_i(pin), .pwm_level_i(pwm_lv),
    .pwm_oe_i(pwm_oe), .event_capture_i(ev_cap), .event_cutoff_i(ev_cut),
    .capture_pwm_pin_o(pin_o), .capture_pwm_pin_oe_o(oe_o),
    .filtered_pin_o(flt), .capture_trigger_o(trig), .irq_o(irq));
  pin_side_model pin_side_model_i (.clk_sys_i, .ext_run_i(ext_run),
    .hs_run_i(hs_run), .ext_clk_o(ext_clk), .hs_clk_o(hs_clk),
    .pwm_level_o(pwm_lv), .pwm_oe_o(pwm_oe));

  task chk(input [31:0] seen, input [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task rst();
    rst_b_i <= 1'b0;
    cyc(4);
    rst_b_i <= 1'b1;
  endtask
  // Address and data offered together, each dropped once taken
  task wr(input [7:0] a, input [31:0] dv);
    logic aw_t, w_t;
    aw_t = 1'b0;
    w_t = 1'b0;
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= dv;
    {awvalid, wvalid, bready} <= 3'h7;
    // Each channel is dropped at the edge that took it, never reoffered
    while (!(aw_t && w_t))
    begin
      @(posedge clk_sys_i);
      if (awready === 1'b1) aw_t = 1'b1;
      if (wready === 1'b1) w_t = 1'b1;
      awvalid <= !aw_t;
      wvalid <= !w_t;
    end
    do @(posedge clk_sys_i); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task rd(input [7:0] a, output [31:0] dv);
    @(posedge clk_sys_i);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(posedge clk_sys_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys_i); while (rvalid !== 1'b1);
    dv = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // One-cycle event from the link unit: cutoff when c, else capture
  task ev(input c, input int ch);
    @(posedge clk_sys_i);
    if (c) ev_cut[ch] <= 1'b1;
    else ev_cap[ch] <= 1'b1;
    @(posedge clk_sys_i);
    {ev_cut, ev_cap} <= 4'h0;
  endtask
  // Single-cycle spike on pin C of channel 0, reports if it got through
  task glitch();
    h = 1'b0;
    @(posedge clk_sys_i);
    pin[2] <= 1'b1;
    @(posedge clk_sys_i);
    pin[2] <= 1'b0;
    repeat (10) @(posedge clk_sys_i) h = h | (flt[2] === 1'b1);
  endtask
  task done(input string name);
    $display("test %s finished", name);
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Cuts a hang short well past the expected run length
  initial
  begin
    #500000;
    n_errors++;
    end_of_test();
  end

  initial
  begin
    msk = '{32'hFF, 32'hFF, 32'h7, 32'h7, 32'h80, 32'h33, 32'hF, 32'h3,
      32'hFFFF, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'hF};
    v = $urandom(32'h22584737);
    rst();
    // Reset values, then random write and readback against the model
    for (k = 0; k < 14; k++)
    begin
      m[k] = 32'h0;
      rd(8'(k * 4), v);
      chk(v, m[k]);
    end
    for (k = 0; k < 14; k++)
    begin
      if (k == 6 || (k > 9 && k < 13)) continue;
      d = $urandom;
      if (k == 2 || k == 3) d = d % 6;
      if (k == 7) d = d & 32'h2;
      wr(8'(k * 4), d);
      m[k] = d & msk[k];
      rd(8'(k * 4), v);
      chk(v, m[k]);
    end
    wr(8'h40, 32'hFF);
    chk(resp, 2'h2);
    rd(8'h40, v);
    chk(resp, 2'h2);
    chk(v, 32'h0);
    done("registers");
    // Every count source reaches general A = 5 and stops there
    for (s = 0; s < 6; s++)
    begin
      rst();
      ext_run = (s == 5);
      wr(8'h08, s);
      wr(8'h20, 32'h5);
      cyc(20);
      rd(8'h28, v);
      chk(v, 32'h0);
      wr(8'h18, 32'h1);
      cyc(400);
      rd(8'h28, v);
      chk(v, 32'h5);
      rd(8'h18, v);
      chk(v, 32'h0);
    end
    ext_run = 0;
    done("count sources");
    // Continue on match, match interrupt masked then raised then cleared
    rst();
    wr(8'h20, 32'h3);
    wr(8'h08, 32'h0);
    wr(8'h18, 32'h5);
    cyc(60);
    chk(irq, 1'b0);
    rd(8'h18, v);
    chk(v, 32'h5);
    rd(8'h28, v);
    chk(v <= 3, 1'b1);
    wr(8'h34, 32'h4);
    cyc(3);
    chk(irq, 1'b1);
    wr(8'h18, 32'h0);
    rd(8'h28, d);
    cyc(50);
    rd(8'h28, v);
    chk(v, d);
    rd(8'h30, v);
    chk(v & 32'h4, 32'h4);
    rd(8'h30, v);
    chk(v, 32'h0);
    cyc(3);
    chk(irq, 1'b0);
    done("match and interrupt");
    // External cutoff gated by its enable, B pins per channel bit
    rst();
    cut_b <= 1'b0;
    cyc(6);
    rd(8'h10, v);
    chk(v, 32'h0);
    chk(oe_o, 8'hFF);
    wr(8'h10, 32'h80);
    cyc(6);
    rd(8'h10, v);
    chk(v, 32'h81);
    chk(oe_o, 8'h22);
    wr(8'h00, 32'h10);
    cyc(3);
    chk(oe_o, 8'h20);
    cut_b <= 1'b1;
    cyc(4);
    wr(8'h10, 32'h80);
    cyc(3);
    rd(8'h10, v);
    chk(v, 32'h80);
    chk(oe_o, 8'hFF);
    ev(1'b1, 1);
    cyc(3);
    chk(oe_o, 8'hFF);
    wr(8'h14, 32'h20);
    ev(1'b1, 1);
    cyc(3);
    chk(oe_o, 8'h2F);
    rd(8'h10, v);
    chk(v, 32'h81);
    done("cutoff");
    // Capture trigger from the event or from pin A, never both
    rst();
    t0 = trig_n;
    ev(1'b0, 0);
    cyc(4);
    chk(trig_n - t0, 0);
    wr(8'h14, 32'h1);
    ev(1'b0, 0);
    cyc(4);
    chk(trig_n - t0, 1);
    pin[0] <= 1'b1;
    cyc(8);
    chk(trig_n - t0, 1);
    wr(8'h14, 32'h0);
    pin[0] <= 1'b0;
    cyc(8);
    pin[0] <= 1'b1;
    cyc(8);
    chk(trig_n - t0, 2);
    done("capture");
    // Filter off passes spikes, on blocks them, rate follows clock pick
    glitch();
    chk(h, 1'b1);
    wr(8'h00, 32'h84);
    glitch();
    chk(h, 1'b0);
    pin[2] <= 1'b1;
    cyc(12);
    chk(flt[2], 1'b1);
    wr(8'h00, 32'h04);
    pin[2] <= 1'b0;
    cyc(20);
    chk(flt[2], 1'b1);
    cyc(150);
    chk(flt[2], 1'b0);
    wr(8'h1C, 32'h2);
    wr(8'h00, 32'h84);
    pin[2] <= 1'b1;
    cyc(50);
    chk(flt[2], 1'b0);
    hs_run = 1'b1;
    cyc(50);
    chk(flt[2], 1'b1);
    hs_run = 1'b0;
    done("filter");
    end_of_test();
  end
endmodule // timer_filter_cutoff_control_bench
